// >>> core/pcgs_pkg.sv
package pcgs_pkg;

  // ****************************************
  // register byte offsets
  // ****************************************
  localparam logic [11:0] PCGS_GATES_OFS  = 12'h008;
  localparam logic [11:0] PCGS_HEALTH_OFS = 12'h00c;
  localparam logic [11:0] PCGS_ISTAT_OFS  = 12'h010;
  localparam logic [11:0] PCGS_IMASK_OFS  = 12'h014;
  localparam logic [11:0] PCGS_UNLOCK_OFS = 12'h100;

  // ****************************************
  // field positions
  // ****************************************
  localparam int PCGS_WDOG_BIT  = 0;
  localparam int PCGS_RTC_BIT   = 1;
  localparam int PCGS_TMR0_BIT  = 2;
  localparam int PCGS_TMR3_BIT  = 5;
  localparam int PCGS_FDIV_BIT  = 6;
  localparam int PCGS_HXTL_BIT  = 0;
  localparam int PCGS_LXTL_BIT  = 1;
  localparam int PCGS_PLL_BIT   = 2;
  localparam int PCGS_SRC_BIT   = 3;
  localparam int PCGS_FRC_BIT   = 4;
  localparam int PCGS_FAIL_BIT  = 7;
  localparam int PCGS_IRQ_FAIL  = 0;
  localparam int PCGS_IRQ_PLL   = 1;

  // ****************************************
  // reset values and unlock keys
  // ****************************************
  localparam logic [6:1] PCGS_GATES_RST = 6'h00;
  localparam logic       PCGS_FAIL_RST  = 1'b0;
  localparam logic [1:0] PCGS_IRQ_RST   = 2'h0;
  localparam logic [7:0] PCGS_KEY1      = 8'h59;
  localparam logic [7:0] PCGS_KEY2      = 8'h16;
  localparam logic [7:0] PCGS_KEY3      = 8'h88;

  // protection sequence progress
  typedef enum logic [1:0] {
    PCGS_LOCKED = 2'b00,
    PCGS_SEEN1  = 2'b01,
    PCGS_SEEN2  = 2'b10,
    PCGS_OPEN   = 2'b11
  } pcgs_unlock_t;

endpackage

// >>> core/pcgs_clock_gates.sv
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
// Behaviour
// (R01) Gate bit 6 passes the frequency divider output clock when one and stops it when zero.
// (R02) Gate bits 5 to 2 each pass one timer clock, timer three at bit 5 and timer zero at bit 2.
// (R03) Gate bit 1 gates only the real-time-clock bus clock; the counting engine keeps running.
// (R04) The watchdog gate at bit 0 changes only after the key writes 59h, 16h, 88h in order.
// (R05) After reset the watchdog gate takes its value from bit 31 of the flash configuration word.
// (R06) Each system clock switch sets the failure flag if the target is unstable, else clears it.
// (R07) Writing one to the failure flag clears it, zero leaves it, and it is write-protected.
// (R08) Status bit 4 is one while the fast internal oscillator is stable.
// (R09) Status bit 3 is one while the slow internal oscillator is stable.
// (R10) Status bit 2 is one while the PLL output is stable.
// (R11) The health register exists only when the low-density build parameter is set.
// (R12) Status bit 1 is one while the low-speed crystal is stable.
// (R13) Status bit 0 is one while the high-speed crystal is stable.
// (R14) Every stability input passes a two-flop synchroniser before it is reported; switch_target_stable sets the failure flag with no synchroniser.
// (R15) Reserved bits of both registers read zero and ignore writes.
module pcgs_clock_gates
  import pcgs_pkg::*;
#(
  parameter bit LOW_DENSITY = 1'b1
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        flash_cfg_watchdog_bit,
  input  wire logic        fast_rc_stable_in,
  input  wire logic        slow_rc_stable_in,
  input  wire logic        pll_locked_in,
  input  wire logic        low_crystal_stable_in,
  input  wire logic        high_crystal_stable_in,
  input  wire logic        clock_switch_pulse,
  input  wire logic        switch_target_stable,
  output logic             divider_output_gate,
  output logic             timer3_gate,
  output logic             timer2_gate,
  output logic             timer1_gate,
  output logic             timer0_gate,
  output logic             rtc_bus_gate,
  output logic             watchdog_gate,
  output logic             irq
);

  // ****************************************
  // declarations
  // ****************************************
  logic [6:1]   gates_r;
  logic [6:1]   gates_nxt;
  logic         wdog_r;
  logic         wdog_nxt;
  logic         wdog_loaded_r;
  logic         wdog_loaded_nxt;
  logic         fail_r;
  logic         fail_nxt;
  pcgs_unlock_t lock_r;
  pcgs_unlock_t lock_nxt;
  logic [1:0]   istat_r;
  logic [1:0]   istat_nxt;
  logic [1:0]   imask_r;
  logic [1:0]   imask_nxt;
  logic [31:0]  rdata_r;
  logic [31:0]  rdata_nxt;
  logic         err_r;
  logic         err_nxt;
  logic [4:0]   stb_meta_r;
  logic [4:0]   stb_sync_r;
  logic         pll_prev_r;
  logic         wr_en;
  logic         setup;
  logic         unlocked;
  logic         fail_event;
  logic         pll_lost;
  logic         mapped;
  logic [31:0]  health_view;
  logic [4:0]   stb_raw;

  // ****************************************
  // stability synchronisers
  // ****************************************

  // raw stability levels, packed in status bit order
  assign stb_raw = {fast_rc_stable_in, slow_rc_stable_in, pll_locked_in,
                    low_crystal_stable_in, high_crystal_stable_in};

  // two flops per level; the first feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stb_meta_r <= 5'h00;
      stb_sync_r <= 5'h00;
      pll_prev_r <= 1'b0;
    end else begin
      stb_meta_r <= stb_raw;        // [R14]
      stb_sync_r <= stb_meta_r;     // [R14]
      pll_prev_r <= stb_sync_r[PCGS_PLL_BIT];
    end
  end

  // ****************************************
  // bus decode and events
  // ****************************************

  // access-phase write and setup-phase strobe
  assign wr_en    = psel & penable & pwrite;
  assign setup    = psel & ~penable;
  assign unlocked = (lock_r == PCGS_OPEN);
  assign pready   = 1'b1;
  assign prdata   = rdata_r;
  assign pslverr  = err_r;

  // switch failure and loss of pll lock raise interrupt events
  assign fail_event = LOW_DENSITY & clock_switch_pulse & ~switch_target_stable;
  assign pll_lost   = pll_prev_r & ~stb_sync_r[PCGS_PLL_BIT];

  // health register view, all zero when the variant lacks it
  always_comb begin
    health_view = 32'h0000_0000;                              // [R15]
    if (LOW_DENSITY) begin                                    // [R11]
      health_view[PCGS_HXTL_BIT] = stb_sync_r[PCGS_HXTL_BIT]; // [R13]
      health_view[PCGS_LXTL_BIT] = stb_sync_r[PCGS_LXTL_BIT]; // [R12]
      health_view[PCGS_PLL_BIT]  = stb_sync_r[PCGS_PLL_BIT];  // [R10]
      health_view[PCGS_SRC_BIT]  = stb_sync_r[PCGS_SRC_BIT];  // [R09]
      health_view[PCGS_FRC_BIT]  = stb_sync_r[PCGS_FRC_BIT];  // [R08]
      health_view[PCGS_FAIL_BIT] = fail_r;
    end
  end

  // ****************************************
  // protection sequence
  // ****************************************

  // keys must arrive in order; any other write to the register relocks
  always_comb begin
    lock_nxt = lock_r;
    if (wr_en && paddr == PCGS_UNLOCK_OFS) begin
      case (lock_r)
        PCGS_LOCKED: begin
          lock_nxt = (pwdata[7:0] == PCGS_KEY1) ? PCGS_SEEN1 : PCGS_LOCKED; // [R04]
        end
        PCGS_SEEN1: begin
          lock_nxt = (pwdata[7:0] == PCGS_KEY2) ? PCGS_SEEN2 : PCGS_LOCKED; // [R04]
        end
        PCGS_SEEN2: begin
          lock_nxt = (pwdata[7:0] == PCGS_KEY3) ? PCGS_OPEN : PCGS_LOCKED;  // [R04]
        end
        default: begin
          lock_nxt = PCGS_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_r <= PCGS_LOCKED;
    end else begin
      lock_r <= lock_nxt;
    end
  end

  // ****************************************
  // gates, watchdog gate and failure flag
  // ****************************************

  // register next values
  always_comb begin
    gates_nxt       = gates_r;
    wdog_nxt        = wdog_r;
    wdog_loaded_nxt = 1'b1;
    fail_nxt        = fail_r;
    if (!wdog_loaded_r) begin
      wdog_nxt = flash_cfg_watchdog_bit;                    // [R05]
    end else if (wr_en && paddr == PCGS_GATES_OFS && unlocked) begin
      wdog_nxt = pwdata[PCGS_WDOG_BIT];                     // [R04]
    end
    if (wr_en && paddr == PCGS_GATES_OFS) begin
      gates_nxt = pwdata[6:1];                              // [R15]
    end
    if (wr_en && paddr == PCGS_HEALTH_OFS && unlocked && pwdata[PCGS_FAIL_BIT]) begin
      fail_nxt = 1'b0;                                      // [R07]
    end
    if (clock_switch_pulse) begin
      fail_nxt = ~switch_target_stable;                     // [R06]
    end
    if (!LOW_DENSITY) begin
      fail_nxt = PCGS_FAIL_RST;                             // [R11]
    end
  end

  // reset loads constants; the flash bit is caught on the first edge after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gates_r       <= PCGS_GATES_RST;
      wdog_r        <= 1'b0;
      wdog_loaded_r <= 1'b0;                                // [R05]
      fail_r        <= PCGS_FAIL_RST;
    end else begin
      gates_r       <= gates_nxt;
      wdog_r        <= wdog_nxt;
      wdog_loaded_r <= wdog_loaded_nxt;
      fail_r        <= fail_nxt;
    end
  end

  // gate levels towards the clock tree
  assign divider_output_gate = gates_r[PCGS_FDIV_BIT];      // [R01]
  assign timer3_gate         = gates_r[PCGS_TMR3_BIT];      // [R02]
  assign timer2_gate         = gates_r[PCGS_TMR0_BIT + 2];  // [R02]
  assign timer1_gate         = gates_r[PCGS_TMR0_BIT + 1];  // [R02]
  assign timer0_gate         = gates_r[PCGS_TMR0_BIT];      // [R02]
  assign rtc_bus_gate        = gates_r[PCGS_RTC_BIT];       // [R03]
  assign watchdog_gate       = wdog_r;

  // ****************************************
  // interrupt status and mask
  // ****************************************

  // sticky bits, write one to clear; a new event wins over the clear
  always_comb begin
    istat_nxt = istat_r;
    imask_nxt = imask_r;
    if (wr_en && paddr == PCGS_ISTAT_OFS) begin
      istat_nxt = istat_r & ~pwdata[1:0];
    end
    if (wr_en && paddr == PCGS_IMASK_OFS) begin
      imask_nxt = pwdata[1:0];
    end
    if (fail_event) begin
      istat_nxt[PCGS_IRQ_FAIL] = 1'b1;
    end
    if (pll_lost) begin
      istat_nxt[PCGS_IRQ_PLL] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_r <= PCGS_IRQ_RST;
      imask_r <= PCGS_IRQ_RST;
    end else begin
      istat_r <= istat_nxt;
      imask_r <= imask_nxt;
    end
  end

  // level interrupt while any unmasked bit is set
  assign irq = |(istat_r & imask_r);

  // ****************************************
  // read data path
  // ****************************************

  // read data and error are captured in the setup cycle
  always_comb begin
    rdata_nxt = rdata_r;
    err_nxt   = err_r;
    mapped    = 1'b1;
    if (setup) begin
      rdata_nxt = 32'h0000_0000;                            // [R15]
      case (paddr)
        PCGS_GATES_OFS: begin
          rdata_nxt[6:1]           = gates_r;
          rdata_nxt[PCGS_WDOG_BIT] = wdog_r;
        end
        PCGS_HEALTH_OFS: begin
          rdata_nxt = health_view;
        end
        PCGS_ISTAT_OFS: begin
          rdata_nxt[1:0] = istat_r;
        end
        PCGS_IMASK_OFS: begin
          rdata_nxt[1:0] = imask_r;
        end
        PCGS_UNLOCK_OFS: begin
          rdata_nxt[0] = unlocked;
        end
        default: begin
          mapped = 1'b0;
        end
      endcase
      err_nxt = ~mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h0000_0000;
      err_r   <= 1'b0;
    end else begin
      rdata_r <= rdata_nxt;
      err_r   <= err_nxt;
    end
  end

endmodule

// >>> testbench/pcgs_clock_gates_monitor.sv
`timescale 1ns/1ps
module pcgs_clock_gates_monitor
  import pcgs_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_cfg_watchdog_bit,
  input wire logic        pll_locked_in,
  input wire logic        divider_output_gate,
  input wire logic        timer3_gate,
  input wire logic        timer2_gate,
  input wire logic        timer1_gate,
  input wire logic        timer0_gate,
  input wire logic        rtc_bus_gate,
  input wire logic        watchdog_gate
);
  // ****************************************
  // access decode
  // ****************************************
  logic       wr_gates;
  logic       mapped;
  logic [5:0] gate_bits;
  // write access to the gate register and address map lookup
  assign wr_gates  = psel && penable && pwrite && (paddr == PCGS_GATES_OFS);
  assign mapped    = paddr inside {PCGS_GATES_OFS, PCGS_HEALTH_OFS, PCGS_ISTAT_OFS,
                                   PCGS_IMASK_OFS, PCGS_UNLOCK_OFS};
  assign gate_bits = {divider_output_gate, timer3_gate, timer2_gate, timer1_gate,
                      timer0_gate, rtc_bus_gate};

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_rd(ofs);
    psel && !penable && !pwrite && (paddr == ofs);
  endsequence
  AST_READY: assert property (pready == 1'b1)
    else $error("pready dropped");
  AST_WDOG_RST: assert property ($rose(presetn) |=> watchdog_gate == $past(flash_cfg_watchdog_bit))
    else $error("watchdog gate did not load flash bit");
  AST_GATE_WR: assert property (wr_gates |=> gate_bits == $past(pwdata[6:1]))
    else $error("gate bits differ from written data");
  AST_GATE_HOLD: assert property (!wr_gates |=> $stable(gate_bits))
    else $error("gate bits changed without a write");
  AST_WDOG_HOLD: assert property ($changed(watchdog_gate) && $past(presetn, 2) |-> $past(wr_gates))
    else $error("watchdog gate changed without a write");
  AST_RSVD_GATES: assert property (s_rd(PCGS_GATES_OFS) |=> prdata[31:7] == '0)
    else $error("reserved gate bits not zero");
  AST_RSVD_HEALTH: assert property (s_rd(PCGS_HEALTH_OFS) |=> prdata[31:8] == '0 && prdata[6:5] == '0)
    else $error("reserved health bits not zero");
  AST_SLVERR: assert property (s_setup |=> pslverr == !$past(mapped))
    else $error("error response wrong for address");
  AST_PLL_SYNC: assert property (s_rd(PCGS_HEALTH_OFS) ##0 ($past(presetn, 4) && $stable(pll_locked_in)
    && $past(pll_locked_in, 2) == pll_locked_in && $past(pll_locked_in, 3) == pll_locked_in)
    |=> prdata[PCGS_PLL_BIT] == $past(pll_locked_in))
    else $error("pll stable bit does not follow input");
endmodule

bind pcgs_clock_gates pcgs_clock_gates_monitor u_mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .flash_cfg_watchdog_bit, .pll_locked_in, .divider_output_gate, .timer3_gate, .timer2_gate,
  .timer1_gate, .timer0_gate, .rtc_bus_gate, .watchdog_gate
);

// >>> testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import pcgs_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        flash_bit;
  logic [4:0]  stab;
  logic        sw_pulse;
  logic        sw_tgt;
  logic [6:0]  gates;
  logic        irq;
  logic [6:0]  gm;
  logic        fail_m;
  logic [31:0] seed;
  logic [31:0] q;
  logic        e;
  int          miscompares;
  int          total_checks;

  pcgs_clock_gates DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_cfg_watchdog_bit(flash_bit), .fast_rc_stable_in(stab[4]),
    .slow_rc_stable_in(stab[3]), .pll_locked_in(stab[2]), .low_crystal_stable_in(stab[1]),
    .high_crystal_stable_in(stab[0]), .clock_switch_pulse(sw_pulse),
    .switch_target_stable(sw_tgt), .divider_output_gate(gates[6]), .timer3_gate(gates[5]),
    .timer2_gate(gates[4]), .timer1_gate(gates[3]), .timer0_gate(gates[2]),
    .rtc_bus_gate(gates[1]), .watchdog_gate(gates[0]), .irq(irq)
  );

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected health word from stability inputs and modelled flag
  function automatic logic [31:0] hexp(input logic [4:0] s);
    return {24'h00_0000, fail_m, 2'b00, s};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, exp);
  endtask
  task automatic unlock();
    wr(PCGS_UNLOCK_OFS, 32'h0000_0059);
    wr(PCGS_UNLOCK_OFS, 32'h0000_0016);
    wr(PCGS_UNLOCK_OFS, 32'h0000_0088);
  endtask
  // one-cycle clock switch event with a given target stability
  task automatic pulse(input logic t);
    @(posedge pclk);
    sw_pulse <= 1'b1;
    sw_tgt <= t;
    @(posedge pclk);
    sw_pulse <= 1'b0;
    fail_m = ~t;
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // clock, watchdog and main sequence
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    stop_test();
  end
  initial begin
    {psel, penable, pwrite, sw_pulse, sw_tgt, presetn} = '0;
    paddr = '0;
    pwdata = '0;
    stab = 5'h1f;
    flash_bit = 1'b1;
    seed = 32'h4c01_31a0;
    fail_m = 1'b0;
    total_checks = 0;
    miscompares = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    #1;
    gm = 7'h01;
    chk(gates, gm);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      q = (i == 0) ? 32'hffff_ffff : ((i == 1) ? 32'h0000_0000 : seed);
      gm[6:1] = q[6:1];
      wr(PCGS_GATES_OFS, q);
      chk(gates, gm);
      rdc(PCGS_GATES_OFS, gm);
    end
    wr(PCGS_UNLOCK_OFS, 32'h0000_0059);
    wr(PCGS_UNLOCK_OFS, 32'h0000_0088);
    wr(PCGS_UNLOCK_OFS, 32'h0000_0016);
    wr(PCGS_GATES_OFS, 32'h0000_0000);
    gm = 7'h01;
    chk(gates, gm);
    unlock();
    wr(PCGS_GATES_OFS, 32'h0000_007e);
    gm = 7'h7e;
    chk(gates, gm);
    wr(PCGS_UNLOCK_OFS, 32'h0000_0000); // any key write while open relocks
    wr(PCGS_GATES_OFS, 32'h0000_0041);
    gm = 7'h40;
    chk(gates, gm);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      @(posedge pclk);
      stab <= seed[4:0];
      repeat (4) @(posedge pclk);
      rdc(PCGS_HEALTH_OFS, hexp(stab));
    end
    wr(PCGS_IMASK_OFS, 32'h0000_0001);
    pulse(1'b0);
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    chk(irq, 32'h0000_0001);
    wr(PCGS_HEALTH_OFS, 32'h0000_0080);
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    unlock();
    wr(PCGS_HEALTH_OFS, 32'h0000_0000);
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    wr(PCGS_UNLOCK_OFS, 32'h0000_0000); // relock so the key sequence starts afresh
    unlock();
    wr(PCGS_HEALTH_OFS, 32'h0000_0080);
    fail_m = 1'b0;
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    wr(PCGS_ISTAT_OFS, 32'h0000_0001);
    chk(irq, 32'h0000_0000);
    pulse(1'b1);
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    pulse(1'b0);
    pulse(1'b1);
    rdc(PCGS_HEALTH_OFS, hexp(stab));
    chk(irq, 32'h0000_0001);
    wr(PCGS_ISTAT_OFS, 32'h0000_0001);
    wr(PCGS_IMASK_OFS, 32'h0000_0000);
    pulse(1'b0);
    chk(irq, 32'h0000_0000);
    // loss of pll lock raises status bit 1 and the interrupt when unmasked
    @(posedge pclk);
    stab[2] <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(PCGS_ISTAT_OFS, 32'h0000_0003);
    wr(PCGS_IMASK_OFS, 32'h0000_0002);
    chk(irq, 32'h0000_0000);
    @(posedge pclk);
    stab[2] <= 1'b0;
    repeat (4) @(posedge pclk);
    #1;
    chk(irq, 32'h0000_0001);
    rdc(PCGS_ISTAT_OFS, 32'h0000_0002);
    apb(1'b0, 12'h040, 32'h0000_0000);
    chk({e, q[30:0]}, 32'h8000_0000);
    stop_test();
  end
endmodule
